// file: inc/ts_pcr_pkg.sv
// Purpose: shared constants, types and helpers of the output timing block
// Assumes: one 10 MHz system clock, APB register access
// Notes:   clock references are held as {33-bit base, 9-bit extension}
package ts_pcr_pkg;

   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int          CLK_PERIOD_NS   = 100;
   localparam logic [31:0] SYS_HZ          = 32'h00989680;
   localparam logic [31:0] REF_HZ          = 32'h07735940;
   localparam logic [31:0] PCR_HZ          = 32'h019BFCC0;
   localparam logic [1:0]  PCR_STEP_INT    = 2'h2;
   localparam logic [31:0] PCR_FRAC_INC    = PCR_HZ - {SYS_HZ[30:0], 1'b0};
   localparam logic [9:0]  PCR_EXT_MOD     = 10'h12C;
   localparam int          PCR_RESID_NS    = 500;
   localparam logic [8:0]  PCR_RESID_TICKS = 9'(PCR_RESID_NS * 27 / 1000);
   localparam int          SAMPLE_GAP_MS   = 728;
   localparam logic [32:0] GAP_BASE        = 33'(SAMPLE_GAP_MS * 90);
   localparam int          ERR_LIMIT_S     = 46;
   localparam logic [32:0] ERR_BASE        = 33'(ERR_LIMIT_S * 90000);
   localparam int          ONE_SEC_NS      = 1000000000;
   localparam int          SEC_CYCLES      = ONE_SEC_NS / CLK_PERIOD_NS;

   // -------------------------------------------------------------
   // limits and stream layout
   // -------------------------------------------------------------
   localparam logic [31:0] NCO_MIN_HZ      = 32'h00000078;
   localparam logic [31:0] NCO_MAX_HZ      = 32'h03B9ACA0;
   localparam logic [31:0] PLL_MIN_HZ      = 32'h000C03C9;
   localparam logic [31:0] PLL_MAX_HZ      = 32'h017D7840;
   localparam logic [15:0] PAUSE_FILL_PKTS = 16'h0400;
   localparam logic [7:0]  PKT_BYTES       = 8'hBC;
   localparam logic [7:0]  AF_CTRL_BYTE    = 8'h03;
   localparam logic [7:0]  AF_LEN_BYTE     = 8'h04;
   localparam logic [7:0]  AF_FLAG_BYTE    = 8'h05;
   localparam logic [7:0]  PCR_FIRST_BYTE  = 8'h06;
   localparam logic [7:0]  PCR_LAST_BYTE   = 8'h0B;
   localparam int          AF_PRESENT_BIT  = 5;
   localparam int          PCR_FLAG_BIT    = 4;

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   localparam logic [7:0]  CTRL_ADDR       = 8'h00;
   localparam logic [7:0]  NCO_FREQ_ADDR   = 8'h04;
   localparam logic [7:0]  PLL_FREQ_ADDR   = 8'h08;
   localparam logic [7:0]  PKT_RATE_ADDR   = 8'h0C;
   localparam logic [7:0]  IRQ_STAT_ADDR   = 8'h10;
   localparam logic [7:0]  IRQ_EN_ADDR     = 8'h14;
   localparam logic [7:0]  IRQ_CLR_ADDR    = 8'h18;
   localparam logic [7:0]  STATUS_ADDR     = 8'h1C;
   localparam int          CTRL_EN_BIT     = 0;
   localparam int          CTRL_PLL_BIT    = 1;
   localparam int          IRQ_W           = 3;
   localparam int          IRQ_OVF_BIT     = 0;
   localparam int          IRQ_RESTART_BIT = 1;
   localparam int          IRQ_SEC_BIT     = 2;
   localparam logic [31:0] NCO_FREQ_RST    = 32'h004C4B40;
   localparam logic [31:0] PLL_FREQ_RST    = 32'h017D7840;

   typedef logic [41:0] pcr_t;

   // -------------------------------------------------------------
   // clock reference arithmetic
   // -------------------------------------------------------------
   function automatic pcr_t pcrAdd(input pcr_t a, input pcr_t b);
      logic [9:0] ext;
      logic       carry;
      ext   = {1'b0, a[8:0]} + {1'b0, b[8:0]};
      carry = (ext >= PCR_EXT_MOD);
      if (carry)
      begin
         ext = ext - PCR_EXT_MOD;
      end
      return {a[41:9] + b[41:9] + {32'h0, carry}, ext[8:0]};
   endfunction

   function automatic pcr_t pcrSub(input pcr_t a, input pcr_t b);
      logic [9:0] ext;
      logic       borrow;
      borrow = (a[8:0] < b[8:0]);
      ext    = {1'b0, a[8:0]} - {1'b0, b[8:0]};
      if (borrow)
      begin
         ext = ext + PCR_EXT_MOD;
      end
      return {a[41:9] - b[41:9] - {32'h0, borrow}, ext[8:0]};
   endfunction

endpackage

// file: src/rate_nco.sv
// Purpose: modulo phase accumulator giving one carry pulse per wrap
// Assumes: inc not above MOD
// Notes:   carry rate is clock rate * inc / MOD
`timescale 1ns/1ps
module rate_nco #(
   parameter int          W   = 32,
   parameter logic [31:0] MOD = 32'h07735940
) (
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] inc,
   output logic              carry
);

   logic [W:0] acc;
   logic [W:0] sum;

   assign sum = acc + {1'b0, inc};

   // -------------------------------------------------------------
   // accumulator
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         acc   <= '0;
         carry <= 1'b0;
      end
      else if (sum >= {1'b0, MOD[W-1:0]})
      begin
         acc   <= sum - {1'b0, MOD[W-1:0]};
         carry <= 1'b1;
      end
      else
      begin
         acc   <= sum;
         carry <= 1'b0;
      end
   end

endmodule

// file: src/ts_output_clock_pcr_corrector.sv
// Purpose: output clock source, clock reference restamping, rate and overflow monitor
// Assumes: byte stream with start-of-packet marks and a stream context number
// Notes:   APB slave, one wait-free access phase, read data loaded at setup
//
// Operation
// - the oscillator clock is synthesized from the reference, 1 Hz steps, 120 Hz to 62.5 MHz.
// - synthesized clock edges fall on reference edges, so adjacent periods differ by one reference period.
// - a second source, an external low-jitter synthesizer limited to 787401 Hz to 25 MHz, is selectable.
// - 8192 correction contexts keep separate state for each referenced stream.
// - the corrector enable is its reset: disabling clears every context so correction restarts.
// - while enabled every clock reference except the first of each context is rewritten, aiming at a residual error within 500 ns.
// - a context restarts when two samples lie over 728 ms apart or its error exceeds 46 s.
// - small errors trim the 27 MHz reference, paused while the buffer holds over 1024 packets.
// - buffer fill that keeps rising past the overflow level raises the overflow indication.
// - output packets are counted per one-second interval.
`timescale 1ns/1ps
module ts_output_clock_pcr_corrector
   import ts_pcr_pkg::*;
#(
   parameter int          SEC_CYCLES_P = SEC_CYCLES,
   parameter int          CTX_COUNT    = 8192,
   parameter int          TRIM_MAX     = 1000,
   parameter logic [15:0] OVF_LEVEL    = 16'h0800
) (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  inData,
   input  wire logic        inValid,
   input  wire logic        inSop,
   input  wire logic [12:0] inCtx,
   output logic             inReady,
   input  wire logic [15:0] bufFill,
   output logic      [7:0]  outData,
   output logic             outValid,
   output logic             outSop,
   input  wire logic        outReady,
   input  wire logic        pllClkIn,
   output logic             tsClk,
   output logic             pllSel,
   output logic      [31:0] pllFreq,
   output logic             overflowLed,
   output logic             irq
);

   localparam int CTX_W = $clog2(CTX_COUNT);

   // ---------------
   // register bus
   // ---------------
   logic              pcrEnable;
   logic [31:0]       ncoFreq;
   logic [31:0]       pktRate;
   logic [IRQ_W-1:0]  irqStat;
   logic [IRQ_W-1:0]  irqEn;
   logic [IRQ_W-1:0]  irqEvent;
   logic signed [15:0] refTrim;
   logic              suspend;
   logic              mapped;
   logic              wrAcc;
   logic              rdSetup;
   logic [IRQ_W-1:0]  irqClr;

   assign mapped  = (paddr <= STATUS_ADDR) && (paddr[1:0] == 2'h0);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign wrAcc   = psel && penable && pwrite && mapped;
   assign rdSetup = psel && !penable && !pwrite;
   assign irqClr  = (wrAcc && paddr == IRQ_CLR_ADDR) ? pwdata[IRQ_W-1:0] : '0;

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pcrEnable <= 1'b0;
         pllSel    <= 1'b0;
         ncoFreq   <= NCO_FREQ_RST;
         pllFreq   <= PLL_FREQ_RST;
         irqEn     <= '0;
      end
      else if (wrAcc)
      begin
         case (paddr)
            CTRL_ADDR:
            begin
               pcrEnable <= pwdata[CTRL_EN_BIT];
               pllSel    <= pwdata[CTRL_PLL_BIT];
            end
            NCO_FREQ_ADDR:
            begin
               ncoFreq <= (pwdata < NCO_MIN_HZ) ? NCO_MIN_HZ :
                          (pwdata > NCO_MAX_HZ) ? NCO_MAX_HZ : pwdata;
            end
            PLL_FREQ_ADDR:
            begin
               pllFreq <= (pwdata < PLL_MIN_HZ) ? PLL_MIN_HZ :
                          (pwdata > PLL_MAX_HZ) ? PLL_MAX_HZ : pwdata;
            end
            IRQ_EN_ADDR:
            begin
               irqEn <= pwdata[IRQ_W-1:0];
            end
            default: irqEn <= irqEn;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         prdata <= '0;
      end
      else if (rdSetup)
      begin
         case (paddr)
            CTRL_ADDR:     prdata <= {30'h0, pllSel, pcrEnable};
            NCO_FREQ_ADDR: prdata <= ncoFreq;
            PLL_FREQ_ADDR: prdata <= pllFreq;
            PKT_RATE_ADDR: prdata <= pktRate;
            IRQ_STAT_ADDR: prdata <= {{(32-IRQ_W){1'b0}}, irqStat};
            IRQ_EN_ADDR:   prdata <= {{(32-IRQ_W){1'b0}}, irqEn};
            STATUS_ADDR:   prdata <= {refTrim, 14'h0, suspend, overflowLed};
            default:       prdata <= '0;
         endcase
      end
   end

   // ---------------
   // interrupts
   // ---------------
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         irqStat <= '0;
         irq     <= 1'b0;
      end
      else
      begin
         irqStat <= (irqStat & ~irqClr) | irqEvent;
         irq     <= |(((irqStat & ~irqClr) | irqEvent) & irqEn);
      end
   end

   // ---------------
   // output clock sources
   // ---------------
   logic ncoCarry;
   logic ncoClk;
   logic pllMeta;
   logic pllSync;

   rate_nco #(
      .W   (32),
      .MOD (REF_HZ)
   ) u_clk_nco (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .inc     ({ncoFreq[30:0], 1'b0}),
      .carry   (ncoCarry)
   );

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ncoClk  <= 1'b0;
         pllMeta <= 1'b0;
         pllSync <= 1'b0;
         tsClk   <= 1'b0;
      end
      else
      begin
         ncoClk  <= ncoClk ^ ncoCarry;
         pllMeta <= pllClkIn;
         pllSync <= pllMeta;
         tsClk   <= pllSel ? pllSync : ncoClk;
      end
   end

   // ---------------
   // local 27 MHz time base
   // ---------------
   logic       fracCarry;
   logic [31:0] fracInc;
   pcr_t       localTime;
   logic [9:0] localExtSum;

   assign fracInc     = PCR_FRAC_INC + {{16{refTrim[15]}}, refTrim};
   assign localExtSum = {1'b0, localTime[8:0]} + {8'h0, PCR_STEP_INT} + {9'h0, fracCarry};

   rate_nco #(
      .W   (32),
      .MOD (SYS_HZ)
   ) u_ref_nco (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .inc     (fracInc),
      .carry   (fracCarry)
   );

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         localTime <= '0;
      end
      else if (localExtSum >= PCR_EXT_MOD)
      begin
         localTime <= {localTime[41:9] + 33'h1, 9'(localExtSum - PCR_EXT_MOD)};
      end
      else
      begin
         localTime <= {localTime[41:9], localExtSum[8:0]};
      end
   end

   // ---------------
   // stream parsing and restamping
   // ---------------
   logic [7:0]       byteIdx;
   logic [7:0]       curIdx;
   logic             inFire;
   logic [CTX_W-1:0] pktCtx;
   logic             afPresent;
   logic             afLenOk;
   logic             pcrHere;
   logic             predOk;
   pcr_t             pred;
   pcr_t             predNext;
   pcr_t             sampleLocal;
   logic [47:0]      predWord;
   logic [39:0]      inShift;
   logic             pcrByte;
   logic             updReq;
   pcr_t             inPcr;
   pcr_t             ctxOffset [CTX_COUNT];
   logic [32:0]      ctxLast   [CTX_COUNT];
   logic [CTX_COUNT-1:0] ctxValid;

   assign inReady = !outValid || outReady;
   assign inFire  = inValid && inReady;
   assign curIdx  = inSop ? 8'h00 : byteIdx;
   assign pcrByte = pcrHere && (curIdx >= PCR_FIRST_BYTE) && (curIdx <= PCR_LAST_BYTE);
   assign predNext = pcrAdd(localTime, ctxOffset[pktCtx]);

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         byteIdx   <= '0;
         pktCtx    <= '0;
         afPresent <= 1'b0;
         afLenOk   <= 1'b0;
         pcrHere   <= 1'b0;
         predOk    <= 1'b0;
         pred      <= '0;
         sampleLocal <= '0;
         predWord  <= '0;
         inShift   <= '0;
         updReq    <= 1'b0;
         inPcr     <= '0;
      end
      else
      begin
         updReq <= 1'b0;
         if (inFire)
         begin
            byteIdx <= (curIdx == PKT_BYTES) ? curIdx : curIdx + 8'h01;
            if (inSop)
            begin
               pktCtx  <= inCtx[CTX_W-1:0];
               pcrHere <= 1'b0;
            end
            if (curIdx == AF_CTRL_BYTE)
            begin
               afPresent <= inData[AF_PRESENT_BIT];
            end
            if (curIdx == AF_LEN_BYTE)
            begin
               afLenOk <= (inData != 8'h00);
            end
            if (curIdx == AF_FLAG_BYTE)
            begin
               pcrHere     <= afPresent && afLenOk && inData[PCR_FLAG_BIT];
               sampleLocal <= localTime;
               pred        <= predNext;
               predOk      <= pcrEnable && ctxValid[pktCtx];
               predWord    <= {predNext[41:9], 6'h3F, predNext[8:0]};
            end
            if (pcrByte)
            begin
               inShift  <= {inShift[31:0], inData};
               predWord <= {predWord[39:0], 8'h00};
            end
            if (pcrByte && curIdx == PCR_LAST_BYTE)
            begin
               updReq <= pcrEnable;
               inPcr  <= {inShift[39:7], inShift[0], inData};
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         outData  <= '0;
         outValid <= 1'b0;
         outSop   <= 1'b0;
      end
      else if (inFire)
      begin
         outData  <= (pcrByte && predOk) ? predWord[47:40] : inData;
         outValid <= 1'b1;
         outSop   <= inSop;
      end
      else if (outReady)
      begin
         outValid <= 1'b0;
      end
   end

   // ---------------
   // context update
   // ---------------
   pcr_t        err;
   logic [32:0] errMag;
   logic [32:0] gap;
   logic        errSmall;
   logic        errPos;
   logic        restart;
   logic        ctxWasValid;

   assign err         = pcrSub(inPcr, pred);
   assign errPos      = !err[41];
   assign errMag      = err[41] ? -err[41:9] : err[41:9];
   assign gap         = sampleLocal[41:9] - ctxLast[pktCtx];
   assign ctxWasValid = ctxValid[pktCtx];
   assign errSmall    = ((err[41:9] == 33'h0) && (err[8:0] <= PCR_RESID_TICKS)) ||
                        ((err[41:9] == '1) && (err[8:0] >= 9'(PCR_EXT_MOD - {1'b0, PCR_RESID_TICKS})));
   assign restart     = updReq && ctxWasValid && ((gap > GAP_BASE) || (errMag > ERR_BASE));
   assign suspend     = bufFill > PAUSE_FILL_PKTS;

   always_ff @(posedge sys_clk)
   begin
      if (updReq)
      begin
         ctxLast[pktCtx] <= sampleLocal[41:9];
         if (!ctxWasValid || restart)
         begin
            ctxOffset[pktCtx] <= pcrSub(inPcr, sampleLocal);
         end
         else if (!errSmall)
         begin
            ctxOffset[pktCtx] <= errPos ? pcrAdd(ctxOffset[pktCtx], 42'h1) :
                                          pcrSub(ctxOffset[pktCtx], 42'h1);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ctxValid <= '0;
      end
      else if (!pcrEnable)
      begin
         ctxValid <= '0;
      end
      else if (updReq)
      begin
         ctxValid[pktCtx] <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         refTrim <= '0;
      end
      else if (updReq && ctxWasValid && !restart && errSmall && !suspend)
      begin
         if (errPos && refTrim < 16'(TRIM_MAX))
         begin
            refTrim <= refTrim + 16'sh0001;
         end
         else if (!errPos && refTrim > -16'(TRIM_MAX))
         begin
            refTrim <= refTrim - 16'sh0001;
         end
      end
   end

   // ---------------
   // overflow and packet rate
   // ---------------
   logic [15:0] fillPrev;
   logic [31:0] secCnt;
   logic [31:0] pktCnt;
   logic        secTick;
   logic        ovfRise;

   assign secTick  = (secCnt == 32'(SEC_CYCLES_P - 1));
   assign ovfRise  = !overflowLed && (bufFill >= OVF_LEVEL) && (bufFill > fillPrev);
   assign irqEvent = {secTick, restart, ovfRise};

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         fillPrev    <= '0;
         overflowLed <= 1'b0;
      end
      else
      begin
         fillPrev <= bufFill;
         if (ovfRise)
         begin
            overflowLed <= 1'b1;
         end
         else if (bufFill < OVF_LEVEL)
         begin
            overflowLed <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         secCnt  <= '0;
         pktCnt  <= '0;
         pktRate <= '0;
      end
      else
      begin
         secCnt <= secTick ? 32'h0 : secCnt + 32'h1;
         if (secTick)
         begin
            pktRate <= pktCnt + {31'h0, outValid && outReady && outSop};
            pktCnt  <= '0;
         end
         else if (outValid && outReady && outSop)
         begin
            pktCnt <= pktCnt + 32'h1;
         end
      end
   end

endmodule

// file: tb/ts_pcr_props.sv
// Purpose: port-level checks of the output timing block
// Assumes: one clock domain, reset rstn
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
module ts_pcr_props
   import ts_pcr_pkg::*;
#(
   parameter logic [15:0] OVF_LEVEL = 16'h0800
) (
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [7:0]  inData,
   input wire logic        inValid,
   input wire logic        inSop,
   input wire logic        inReady,
   input wire logic [7:0]  outData,
   input wire logic        outValid,
   input wire logic        outSop,
   input wire logic        outReady,
   input wire logic [15:0] bufFill,
   input wire logic        pllSel,
   input wire logic [31:0] pllFreq,
   input wire logic        overflowLed
);
   // ---------------
   // helpers
   // ---------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   wire logic       take = inValid && inReady;
   wire logic       wrEn = psel && penable && pwrite && pready;
   logic      [7:0] cnt;
   wire logic [7:0] pos  = inSop ? 8'h00 : cnt;
   always_ff @(posedge sys_clk or negedge rstn)
      if (!rstn)
         cnt <= 8'h00;
      else if (take)
         cnt <= pos + 8'h01;
   // ---------------
   // assertions
   // ---------------
   a_byte_pass: assert property (take && (pos < PCR_FIRST_BYTE || pos > PCR_LAST_BYTE) |=>
      outValid && outData == $past(inData) && outSop == $past(inSop)) else $error("byte altered");
   a_out_hold: assert property (outValid && !outReady |=>
      outValid && $stable(outData) && $stable(outSop)) else $error("output not held");
   a_flow_ready: assert property (inReady == (!outValid || outReady)) else $error("bad inReady");
   a_pll_select: assert property (wrEn && paddr == CTRL_ADDR |=> pllSel == $past(pwdata[1]))
      else $error("pllSel not written");
   a_pll_range: assert property (pllFreq >= PLL_MIN_HZ && pllFreq <= PLL_MAX_HZ)
      else $error("pllFreq out of range");
   a_pll_write: assert property (wrEn && paddr == PLL_FREQ_ADDR && pwdata >= PLL_MIN_HZ
      && pwdata <= PLL_MAX_HZ |=> pllFreq == $past(pwdata)) else $error("pllFreq not written");
   a_ovf_set: assert property (bufFill >= OVF_LEVEL && bufFill > $past(bufFill) |-> ##[1:2] overflowLed)
      else $error("overflow not raised");
   a_ovf_clear: assert property (bufFill < OVF_LEVEL |=> !overflowLed) else $error("overflow not cleared");
   c_packet: cover property (take && inSop);
   c_overflow: cover property ($rose(overflowLed));
   c_pll_write: cover property (wrEn && paddr == PLL_FREQ_ADDR);
endmodule

// file: tb/ts_sink_model.sv
// Purpose: downstream receiver of the output stream
// Assumes: stall pattern chosen by slow
// Notes:   keeps the last packet in cap
`timescale 1ns/1ps
module ts_sink_model (
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire logic [7:0] outData,
   input  wire logic       outValid,
   input  wire logic       outSop,
   input  wire logic       slow,
   output logic            outReady
);
   logic [7:0] cap [0:187];
   int         got;
   logic [1:0] cyc;
   always_ff @(posedge sys_clk or negedge rstn)
      if (!rstn)
      begin
         got      <= 0;
         cyc      <= 2'h0;
         outReady <= 1'b0;
      end
      else
      begin
         cyc      <= cyc + 2'h1;
         outReady <= !slow || cyc != 2'h0;
         if (outValid && outReady)
         begin
            cap[outSop ? 0 : got] <= outData;
            got                   <= outSop ? 1 : got + 1;
         end
      end
endmodule

// file: tb/testbench.sv
// Purpose: register, clock, stream and overflow tests of the timing block
// Assumes: APB master tasks, one-second interval shortened to 1000 cycles
// Notes:   sink model stalls on request
`timescale 1ns/1ps
module testbench;
   import ts_pcr_pkg::*;
   logic sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, inValid = 0, inSop = 0;
   logic pllClkIn = 0, slow = 0, se;
   logic [7:0] paddr = 0, inData = 0;
   logic [31:0] pwdata = 0, rv;
   logic [12:0] inCtx = 0;
   logic [15:0] bufFill = 0;
   wire logic [31:0] prdata, pllFreq;
   wire logic [7:0] outData;
   wire logic pready, pslverr, inReady, outValid, outSop, outReady, tsClk, pllSel, overflowLed, irq;
   int fails = 0, checked = 0, n;
   // ---------------
   // design and partner
   // ---------------
   ts_output_clock_pcr_corrector #(.SEC_CYCLES_P(1000)) u_ts_output_clock_pcr_corrector (
      .sys_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .inData, .inValid, .inSop, .inCtx, .inReady, .bufFill, .outData, .outValid, .outSop,
      .outReady, .pllClkIn, .tsClk, .pllSel, .pllFreq, .overflowLed, .irq);
   ts_sink_model u_ts_sink_model (.sys_clk, .rstn, .outData, .outValid, .outSop, .slow, .outReady);
   always #50 sys_clk = !sys_clk;
   initial #25 forever #400 pllClkIn = !pllClkIn;
   // ---------------
   // tasks
   // ---------------
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic tmo;
      fails++;
      end_sim();
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
      checked++;
      if (s !== e)
      begin
         fails++;
         $display("wrong value %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (++k > 50) tmo();
      end
      while (pready !== 1'b1);
      rv = prdata;
      se = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   function automatic logic [7:0] pb(input int i, input logic [31:0] hi);
      logic [95:0] hd;
      hd = {48'h47010020B710, hi, 16'h0000};
      return (i < 12) ? hd[8*(11-i)+:8] : 8'(i);
   endfunction
   task automatic tog(input int c);
      logic p;
      n = 0;
      p = tsClk;
      repeat (c)
      begin
         @(posedge sys_clk);
         n += (tsClk !== p);
         p = tsClk;
      end
   endtask
   task automatic pk(input logic [12:0] c, input logic [31:0] hi, input logic rw);
      int k;
      inCtx <= c;
      for (int i = 0; i < 188; i++)
      begin
         inValid <= 1'b1;
         inSop   <= (i == 0);
         inData  <= pb(i, hi);
         k = 0;
         do
         begin
            @(posedge sys_clk);
            if (++k > 50) tmo();
         end
         while (inReady !== 1'b1);
      end
      inValid <= 1'b0;
      inSop   <= 1'b0;
      k = 0;
      while (u_ts_sink_model.got != 188)
      begin
         @(posedge sys_clk);
         if (++k > 999) tmo();
      end
      for (int i = 0; i < 188; i++)
         if (i < 6 || i > 11 || !rw)
            chk(u_ts_sink_model.cap[i], pb(i, hi), "outByte");
      if (rw)
         chk(u_ts_sink_model.cap[10][6:1], 6'h3F, "pcrReserved");
      repeat (3) @(posedge sys_clk);
   endtask
   // ---------------
   // main sequence
   // ---------------
   initial
   begin
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      apb(NCO_FREQ_ADDR, 1'b0, 32'h0);
      chk(rv, 32'h004C4B40, "ncoReset");
      apb(PLL_FREQ_ADDR, 1'b0, 32'h0);
      chk(rv, 32'h017D7840, "pllReset");
      apb(8'h20, 1'b0, 32'h0);
      chk({rv[30:0], se}, 32'h1, "unmapped");
      apb(NCO_FREQ_ADDR, 1'b1, 32'h00000010);
      apb(NCO_FREQ_ADDR, 1'b0, 32'h0);
      chk(rv, 32'h00000078, "ncoClamp");
      apb(NCO_FREQ_ADDR, 1'b1, 32'h03B9ACA0);
      repeat (2) @(posedge sys_clk);
      tog(100);
      chk(n, 100, "ncoMaxToggles");
      apb(NCO_FREQ_ADDR, 1'b1, 32'h005F5E10);
      repeat (20) @(posedge sys_clk);
      tog(100);
      chk(n, 10, "ncoToggles");
      apb(PLL_FREQ_ADDR, 1'b1, 32'h00F42400);
      chk(pllFreq, 32'h00F42400, "pllFreq");
      apb(PLL_FREQ_ADDR, 1'b1, 32'h0);
      apb(PLL_FREQ_ADDR, 1'b0, 32'h0);
      chk(rv, 32'h000C03C9, "pllClamp");
      apb(CTRL_ADDR, 1'b1, 32'h2);
      tog(80);
      chk(n > 18 && n < 22, 1, "pllToggles");
      apb(IRQ_CLR_ADDR, 1'b1, 32'h7);
      apb(CTRL_ADDR, 1'b1, 32'h1);
      pk(13'h1, 32'h00001000, 1'b0);
      slow <= 1'b1;
      pk(13'h1, 32'h00001000, 1'b1);
      apb(IRQ_STAT_ADDR, 1'b0, 32'h0);
      chk(rv[1], 1'b0, "noRestart");
      pk(13'h5, 32'h00002000, 1'b0);
      pk(13'h1, 32'h80001000, 1'b1);
      apb(IRQ_STAT_ADDR, 1'b0, 32'h0);
      chk(rv[1], 1'b1, "restart");
      slow <= 1'b0;
      apb(CTRL_ADDR, 1'b1, 32'h0);
      apb(CTRL_ADDR, 1'b1, 32'h1);
      pk(13'h1, 32'h00003000, 1'b0);
      apb(IRQ_EN_ADDR, 1'b1, 32'h1);
      for (int i = 0; i < 40; i++)
      begin
         bufFill <= 16'h07F0 + 16'(i);
         @(posedge sys_clk);
      end
      chk({overflowLed, irq}, 2'h3, "overflowIrq");
      apb(STATUS_ADDR, 1'b0, 32'h0);
      chk(rv[0], 1'b1, "overflowStatus");
      bufFill <= 16'h0000;
      apb(IRQ_CLR_ADDR, 1'b1, 32'h1);
      chk({overflowLed, irq}, 2'h0, "overflowCleared");
      apb(IRQ_STAT_ADDR, 1'b0, 32'h0);
      chk(rv[2], 1'b1, "secondTick");
      end_sim();
   end
endmodule
bind ts_output_clock_pcr_corrector ts_pcr_props #(.OVF_LEVEL(OVF_LEVEL)) u_ts_pcr_props (
   .sys_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .inData, .inValid, .inSop,
   .inReady, .outData, .outValid, .outSop, .outReady, .bufFill, .pllSel, .pllFreq, .overflowLed);
